// ==== hdl/mss_defs.vh ====
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH

// ==================================================================
// Access command codes
`define MSS_CMD_MEAS_WRITE      8'h51
`define MSS_CMD_MEAS_READ       8'h52

// ==================================================================
// Register addresses
`define MSS_ADDR_SELECTOR       8'h07
`define MSS_ADDR_SNAPSHOT       8'h08
`define MSS_ADDR_OVERRIDE       8'h70
`define MSS_ADDR_EXT1_UPPER     8'h80
`define MSS_ADDR_EXT1_LOWER     8'h81
`define MSS_ADDR_EXT2_UPPER     8'h82
`define MSS_ADDR_EXT2_LOWER     8'h83
`define MSS_ADDR_DIE_UPPER      8'h84
`define MSS_ADDR_DIE_LOWER      8'h85
`define MSS_ADDR_ALARM_FIRST    8'h86
`define MSS_ADDR_ALARM_SECOND   8'h87

// ==================================================================
// Selector codes and fields
`define MSS_SEL_W               4
`define MSS_SEL_LOG             4'h0
`define MSS_SEL_ROW1            4'h1
`define MSS_SEL_ROW2            4'h2
`define MSS_SEL_ROW3            4'h3
`define MSS_SEL_ROW4            4'h4
`define MSS_SEL_ROW5            4'h5
`define MSS_SEL_ROW6            4'h6
`define MSS_SEL_RESET           4'h0
`define MSS_SEL_VALID_BIT       7
`define MSS_ROW6_TAIL           3'h5

// ==================================================================
// Override register
`define MSS_OVR_W               6
`define MSS_OVR_RESET           6'h00

// ==================================================================
// Monitor vector carried on the sense link, MSB first
`define MSS_MON_BITS            45
`define MSS_LINK_CNT_W          6

// ==================================================================
// Temperature format
`define MSS_TEMP_W              11
`define MSS_TEMP_RAW_W          12
`define MSS_TEMP_MAX            11'h3ff
`define MSS_TEMP_MAX_RAW        12'h3ff
`define MSS_TEMP_OFF            11'h700
`define MSS_TEMP_CH             3

// ==================================================================
// Timing
`define MSS_CLK_MHZ             200
`define MSS_TEMP_SLOT_NS        100000
`define MSS_TEMP_SLOT_CYC       (`MSS_TEMP_SLOT_NS * `MSS_CLK_MHZ / 1000)

`endif

// ==== hdl/mss_link_rx.v ====
`timescale 1ns/10ps
`include "mss_defs.vh"

module mss_link_rx #(
	parameter BITS = `MSS_MON_BITS
) (
	// Clock and reset
	input  wire            i_sys_clk,
	input  wire            i_rst_b,
	// Sense link pins
	input  wire            i_link_clk,
	input  wire            i_link_data,
	input  wire            i_link_frame,
	// Decoded frame
	output reg  [BITS-1:0] o_vec,
	output reg             o_done
);

	// ==================================================================
	// Two-stage synchronisers
	reg  [1:0]                 clk_s_r;
	reg  [1:0]                 dat_s_r;
	reg  [1:0]                 frm_s_r;
	reg                        clk_d_r;
	reg                        frm_d_r;
	reg  [BITS-1:0]            shf_r;
	reg  [`MSS_LINK_CNT_W-1:0] cnt_r;

	wire clk_rise = clk_s_r[1] & ~clk_d_r;
	wire frm_fall = ~frm_s_r[1] & frm_d_r;

	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			clk_s_r <= 2'h0;
			dat_s_r <= 2'h0;
			frm_s_r <= 2'h0;
			clk_d_r <= 1'b0;
			frm_d_r <= 1'b0;
		end else begin
			clk_s_r <= {clk_s_r[0], i_link_clk};
			dat_s_r <= {dat_s_r[0], i_link_data};
			frm_s_r <= {frm_s_r[0], i_link_frame};
			clk_d_r <= clk_s_r[1];
			frm_d_r <= frm_s_r[1];
		end
	end

	// ==================================================================
	// Shifter; a short or long frame is dropped so a glitch never
	// lands in the snapshot
	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			shf_r  <= {BITS{1'b0}};
			cnt_r  <= {`MSS_LINK_CNT_W{1'b0}};
			o_vec  <= {BITS{1'b0}};
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (frm_fall) begin
				cnt_r <= {`MSS_LINK_CNT_W{1'b0}};
				if (cnt_r == BITS[`MSS_LINK_CNT_W-1:0]) begin
					o_vec  <= shf_r;
					o_done <= 1'b1;
				end
			end else if (frm_s_r[1] && clk_rise) begin
				shf_r <= {shf_r[BITS-2:0], dat_s_r[1]};
				if (cnt_r != {`MSS_LINK_CNT_W{1'b1}})
					cnt_r <= cnt_r + 1'b1;
			end
		end
	end

endmodule

// ==== hdl/mss_monitor_status_readout_regs.v ====
`timescale 1ns/10ps
`include "mss_defs.vh"

// How it works
// - Snapshot tracks selected monitor bits continuously
// - Read command 0x52 at 0x08 returns snapshot
// - Selector rows map monitor bits, MSB first
// - Override drives only outputs set for I2C
// - Override at 0x70: gates 5..2, pins 1..0
// - Unselected outputs ignore their override bit
// - Three channels, upper/lower byte pairs 0x80-0x85
// - Upper holds bits 10..3, lower 2..0 high
// - Enabled channels update readings automatically
// - Update interval grows with enabled channel count
// - Upper byte read latches reading for lower
// - Readings are eleven-bit two's complement
// - One step is a quarter degree
// - Disabled or reset channel reads minus 64
// - Hot readings saturate at 0x3ff
// - No lower clamp on negative readings
// - 0x86 shows first comparator alarms
// - 0x87 shows second comparator alarms
// - Selector bit 7 is snapshot valid flag
module mss_monitor_status_readout_regs #(
	parameter TEMP_SLOT_CYC = `MSS_TEMP_SLOT_CYC,
	parameter SLOT_CNT_W    = 16
) (
	// Clock and reset
	input  wire                       i_sys_clk,
	input  wire                       i_rst_b,
	// Register access from the serial slave engine
	input  wire                       i_acc_stb,
	input  wire [7:0]                 i_acc_cmd,
	input  wire [7:0]                 i_acc_addr,
	input  wire [7:0]                 i_acc_wdata,
	output reg  [7:0]                 o_acc_rdata,
	output reg                        o_acc_ack,
	// Sense link pins
	input  wire                       i_link_clk,
	input  wire                       i_link_data,
	input  wire                       i_link_frame,
	// Device state
	input  wire                       i_safe_state,
	input  wire                       i_log_full,
	input  wire                       i_log_busy,
	// Temperature measurement
	input  wire [`MSS_TEMP_CH-1:0]    i_temp_enable,
	input  wire [`MSS_TEMP_RAW_W-1:0] i_temp_raw_ext1,
	input  wire [`MSS_TEMP_RAW_W-1:0] i_temp_raw_ext2,
	input  wire [`MSS_TEMP_RAW_W-1:0] i_temp_raw_die,
	// Output control
	input  wire [`MSS_OVR_W-1:0]      i_out_i2c_sel,
	input  wire [`MSS_OVR_W-1:0]      i_out_logic,
	output reg  [3:0]                 o_high_voltage_gate_outputs,
	output reg  [1:0]                 o_io_pins
);

	// ==================================================================
	// Channel slots in the reading arrays
	localparam [1:0] CH_EXT1 = 2'h0;
	localparam [1:0] CH_EXT2 = 2'h1;
	localparam [1:0] CH_DIE  = 2'h2;

	// ==================================================================
	// Functions
	function [`MSS_TEMP_W-1:0] temp_code;
		input [`MSS_TEMP_RAW_W-1:0] raw;
		begin
			if (!raw[`MSS_TEMP_RAW_W-1] && raw > `MSS_TEMP_MAX_RAW)
				temp_code = `MSS_TEMP_MAX;
			else
				temp_code = raw[`MSS_TEMP_W-1:0];
		end
	endfunction

	function [1:0] next_ch;
		input [1:0]              cur;
		input [`MSS_TEMP_CH-1:0] en;
		reg   [1:0]              a;
		reg   [1:0]              b;
		begin
			a = (cur == 2'h2) ? 2'h0 : cur + 2'h1;
			b = (a == 2'h2) ? 2'h0 : a + 2'h1;
			if (en[a])
				next_ch = a;
			else if (en[b])
				next_ch = b;
			else
				next_ch = cur;
		end
	endfunction

	function [7:0] record_of;
		input [`MSS_SEL_W-1:0]    sel;
		input [`MSS_MON_BITS-1:0] mon;
		input                     full;
		input                     busy;
		begin
			case (sel)
				`MSS_SEL_LOG:  record_of = {1'b0, full, busy, 5'h05};
				`MSS_SEL_ROW1: record_of = mon[44:37];
				`MSS_SEL_ROW2: record_of = mon[36:29];
				`MSS_SEL_ROW3: record_of = mon[28:21];
				`MSS_SEL_ROW4: record_of = mon[20:13];
				`MSS_SEL_ROW5: record_of = mon[12:5];
				`MSS_SEL_ROW6: record_of = {mon[4:0], `MSS_ROW6_TAIL};
				default:       record_of = 8'h00;
			endcase
		end
	endfunction

	// Upper byte is taken from the live word
	function [7:0] upper_byte;
		input [`MSS_TEMP_W-1:0] v;
		begin
			upper_byte = v[10:3];
		end
	endfunction

	// Lower byte comes from the copy taken at the upper read
	function [7:0] lower_byte;
		input [`MSS_TEMP_W-1:0] v;
		begin
			lower_byte = {v[2:0], 5'h00};
		end
	endfunction

	// Alarm flags sit in the low three bits, the rest read zero
	function [7:0] alarm_byte;
		input [2:0] a;
		begin
			alarm_byte = {5'h00, a};
		end
	endfunction

	// ==================================================================
	// Sense link receiver
	wire [`MSS_MON_BITS-1:0] mon;
	wire                     link_done;

	mss_link_rx #(
		.BITS         (`MSS_MON_BITS)
	) u_link_rx (
		.i_sys_clk    (i_sys_clk),
		.i_rst_b      (i_rst_b),
		.i_link_clk   (i_link_clk),
		.i_link_data  (i_link_data),
		.i_link_frame (i_link_frame),
		.o_vec        (mon),
		.o_done       (link_done)
	);

	// Alarm pairs from row 5 and 6 of the monitor vector
	wire [2:0] alarm_first  = {mon[0], mon[4], mon[2]};
	wire [2:0] alarm_second = {mon[1], mon[5], mon[3]};

	// ==================================================================
	// Access decode
	wire acc_wr = i_acc_stb && (i_acc_cmd == `MSS_CMD_MEAS_WRITE);
	wire acc_rd = i_acc_stb && (i_acc_cmd == `MSS_CMD_MEAS_READ);

	// ==================================================================
	// Snapshot
	reg  [`MSS_SEL_W-1:0] sel_r;
	reg                   pend_r;
	reg                   loaded_r;
	reg                   link_up_r;
	reg  [7:0]            rec_r;
	wire                  snap_valid = loaded_r && !(i_safe_state && !link_up_r);

	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			sel_r     <= `MSS_SEL_RESET;
			pend_r    <= 1'b0;
			loaded_r  <= 1'b0;
			link_up_r <= 1'b0;
			rec_r     <= 8'h00;
		end else begin
			// Refreshed every cycle, far faster than any bus access
			rec_r <= record_of(sel_r, mon, i_log_full, i_log_busy);
			if (link_done)
				link_up_r <= 1'b1;
			if (acc_wr && i_acc_addr == `MSS_ADDR_SELECTOR) begin
				// Only the selector field is stored; bit 7 is status
				sel_r    <= i_acc_wdata[`MSS_SEL_W-1:0];
				pend_r   <= 1'b1;
				loaded_r <= 1'b0;
			end else begin
				pend_r <= 1'b0;
				if (pend_r)
					loaded_r <= 1'b1;
			end
		end
	end

	// ==================================================================
	// Output override
	reg [`MSS_OVR_W-1:0] ovr_r;
	wire [`MSS_OVR_W-1:0] out_mux = (i_out_i2c_sel & ovr_r) |
	                                (~i_out_i2c_sel & i_out_logic);

	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			ovr_r                       <= `MSS_OVR_RESET;
			o_high_voltage_gate_outputs <= 4'h0;
			o_io_pins                   <= 2'h0;
		end else begin
			if (acc_wr && i_acc_addr == `MSS_ADDR_OVERRIDE)
				ovr_r <= i_acc_wdata[`MSS_OVR_W-1:0];
			o_high_voltage_gate_outputs <= out_mux[5:2];
			o_io_pins                   <= out_mux[1:0];
		end
	end

	// ==================================================================
	// Temperature scheduler: one enabled channel per slot, so each enabled
	// channel refreshes every (enabled count) slots
	reg  [SLOT_CNT_W-1:0]  slot_r;
	reg  [1:0]             ch_r;
	reg  [`MSS_TEMP_W-1:0] live_r [0:`MSS_TEMP_CH-1];
	reg  [`MSS_TEMP_W-1:0] hold_r [0:`MSS_TEMP_CH-1];
	wire [1:0]             ch_nxt = next_ch(ch_r, i_temp_enable);
	reg  [`MSS_TEMP_W-1:0] meas;
	integer                k;
	integer                j;

	always @* begin
		case (ch_nxt)
			CH_EXT1: meas = temp_code(i_temp_raw_ext1);
			CH_EXT2: meas = temp_code(i_temp_raw_ext2);
			default: meas = temp_code(i_temp_raw_die);
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			slot_r <= {SLOT_CNT_W{1'b0}};
			ch_r   <= CH_DIE;
			for (k = 0; k < `MSS_TEMP_CH; k = k + 1)
				live_r[k] <= `MSS_TEMP_OFF;
		end else begin
			if (slot_r == TEMP_SLOT_CYC[SLOT_CNT_W-1:0] - 1'b1) begin
				slot_r <= {SLOT_CNT_W{1'b0}};
				ch_r   <= ch_nxt;
				if (i_temp_enable[ch_nxt])
					live_r[ch_nxt] <= meas;
			end else begin
				slot_r <= slot_r + 1'b1;
			end
			// A disabled channel is forced every cycle, winning over a load
			for (k = 0; k < `MSS_TEMP_CH; k = k + 1)
				if (!i_temp_enable[k])
					live_r[k] <= `MSS_TEMP_OFF;
		end
	end

	// ==================================================================
	// Read path and upper-byte latch
	reg [7:0] rd_mux;

	always @* begin
		case (i_acc_addr)
			`MSS_ADDR_SELECTOR:     rd_mux = {snap_valid, 3'h0, sel_r};
			`MSS_ADDR_SNAPSHOT:     rd_mux = rec_r;
			`MSS_ADDR_OVERRIDE:     rd_mux = {2'h0, ovr_r};
			`MSS_ADDR_EXT1_UPPER:   rd_mux = upper_byte(live_r[CH_EXT1]);
			`MSS_ADDR_EXT1_LOWER:   rd_mux = lower_byte(hold_r[CH_EXT1]);
			`MSS_ADDR_EXT2_UPPER:   rd_mux = upper_byte(live_r[CH_EXT2]);
			`MSS_ADDR_EXT2_LOWER:   rd_mux = lower_byte(hold_r[CH_EXT2]);
			`MSS_ADDR_DIE_UPPER:    rd_mux = upper_byte(live_r[CH_DIE]);
			`MSS_ADDR_DIE_LOWER:    rd_mux = lower_byte(hold_r[CH_DIE]);
			`MSS_ADDR_ALARM_FIRST:  rd_mux = alarm_byte(alarm_first);
			`MSS_ADDR_ALARM_SECOND: rd_mux = alarm_byte(alarm_second);
			default:                rd_mux = 8'h00;
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_acc_rdata <= 8'h00;
			o_acc_ack   <= 1'b0;
			for (j = 0; j < `MSS_TEMP_CH; j = j + 1)
				hold_r[j] <= `MSS_TEMP_OFF;
		end else begin
			// Writes to read-only addresses are acked and dropped
			o_acc_ack <= acc_wr || acc_rd;
			if (acc_rd) begin
				o_acc_rdata <= rd_mux;
				case (i_acc_addr)
					`MSS_ADDR_EXT1_UPPER: hold_r[CH_EXT1] <= live_r[CH_EXT1];
					`MSS_ADDR_EXT2_UPPER: hold_r[CH_EXT2] <= live_r[CH_EXT2];
					`MSS_ADDR_DIE_UPPER:  hold_r[CH_DIE]  <= live_r[CH_DIE];
					default:              hold_r[CH_EXT1] <= hold_r[CH_EXT1];
				endcase
			end
		end
	end

endmodule

// ==== dv/mss_assertions.sv ====
`timescale 1ns/10ps
// ==========
// Port checker
module mss_chk (
	input wire       i_sys_clk,
	input wire       i_rst_b,
	input wire       i_acc_stb,
	input wire [7:0] i_acc_cmd,
	input wire [7:0] i_acc_addr,
	input wire [5:0] i_out_i2c_sel,
	input wire [5:0] i_out_logic,
	input wire [7:0] o_acc_rdata,
	input wire       o_acc_ack,
	input wire       i_link_frame,
	input wire [3:0] o_high_voltage_gate_outputs,
	input wire [1:0] o_io_pins
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	wire rd = i_acc_stb && i_acc_cmd == 8'h52;
	wire ok = rd || (i_acc_stb && i_acc_cmd == 8'h51);
	ack_on_take_a: assert property (ok |=> o_acc_ack) else $error("ack missing");
	ack_cause_a: assert property (o_acc_ack |-> $past(ok)) else $error("stray ack");
	bad_cmd_a: assert property (i_acc_stb && !ok |=> !o_acc_ack) else $error("ack on bad cmd");
	rdata_hold_a: assert property (!rd |=> $stable(o_acc_rdata)) else $error("rdata moved");
	ovr_pad_a: assert property (rd && i_acc_addr == 8'h70 |=> o_acc_rdata[7:6] == 2'h0)
		else $error("override pad");
	alarm_pad_a: assert property (rd && i_acc_addr[7:1] == 7'h43 |=> o_acc_rdata[7:3] == 5'h00)
		else $error("alarm pad");
	lower_pad_a: assert property (rd && i_acc_addr inside {8'h81, 8'h83, 8'h85}
		|=> o_acc_rdata[4:0] == 5'h00) else $error("lower pad");
	sel_pad_a: assert property (rd && i_acc_addr == 8'h07 |=> o_acc_rdata[6:4] == 3'h0)
		else $error("selector pad");
	pin_logic_a: assert property (!i_out_i2c_sel[0] |=> o_io_pins[0] == $past(i_out_logic[0]))
		else $error("pin ignores logic");
	gate_logic_a: assert property (i_out_i2c_sel[5:2] == 4'h0
		|=> o_high_voltage_gate_outputs == $past(i_out_logic[5:2])) else $error("gate logic");
	cover property (ok ##1 ok);
	cover property (rd && i_acc_addr == 8'h80);
	cover property ($fell(i_link_frame));
endmodule

bind mss_monitor_status_readout_regs mss_chk u_chk (
	.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_acc_stb(i_acc_stb), .i_acc_cmd(i_acc_cmd),
	.i_acc_addr(i_acc_addr), .i_out_i2c_sel(i_out_i2c_sel), .i_out_logic(i_out_logic),
	.o_acc_rdata(o_acc_rdata), .o_acc_ack(o_acc_ack), .i_link_frame(i_link_frame),
	.o_high_voltage_gate_outputs(o_high_voltage_gate_outputs), .o_io_pins(o_io_pins));

// ==== dv/mss_host.sv ====
`timescale 1ns/10ps
// ==========
// Register master and sense link source
module mss_host (
	input  wire       i_sys_clk,
	input  wire       i_ack,
	input  wire [7:0] i_rdata,
	output reg        o_stb,
	output reg  [7:0] o_cmd,
	output reg  [7:0] o_addr,
	output reg  [7:0] o_wdata,
	output reg        o_lclk,
	output reg        o_ldata,
	output reg        o_frame
);
	initial {o_stb, o_cmd, o_addr, o_wdata, o_lclk, o_ldata, o_frame} = '0;
	// Strobe is a single pulse; holding it would start a second access
	task xfer(input [7:0] c, input [7:0] a, input [7:0] w, output [7:0] d, output k);
		begin
			@(posedge i_sys_clk);
			#1 {o_stb, o_cmd, o_addr, o_wdata} = {1'b1, c, a, w};
			@(posedge i_sys_clk);
			// Ack stands for the one cycle after the take edge; read data holds until the next read
			#1 k = i_ack;
			d = i_rdata;
			{o_stb, o_cmd, o_addr, o_wdata} = {1'b0, ~c, ~a, ~w};
		end
	endtask
	task acc(input [7:0] c, input [7:0] a, input [7:0] w, output [7:0] d, output k);
		reg [7:0] dd;
		reg       kk;
		begin
			xfer(c, a, w, d, k);
			if (c == 8'h52 && (a == 8'h85 || a == 8'h86))
				xfer(8'h52, 8'h70, 8'h00, dd, kk);
		end
	endtask
	// Link clock stands still between frames
	task frame(input [44:0] v, input integer n);
		integer i;
		begin
			o_frame = 1'b1;
			for (i = n - 1; i >= 0; i--) begin
				o_ldata = v[i];
				#62.5 o_lclk = 1'b1;
				#62.5 o_lclk = 1'b0;
			end
			#62.5 o_frame = 1'b0;
			o_ldata = ~o_ldata;
			#250;
		end
	endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
// ==========
// Bench top
module tb_top;
	reg         i_sys_clk = 1'b0;
	reg         i_rst_b = 1'b0;
	reg         full = 1'b0, busy = 1'b0, safe = 1'b1;
	reg  [2:0]  ten = 3'h0;
	reg  [11:0] t1 = 12'h000, t2 = 12'h000, t3 = 12'h000;
	reg  [5:0]  osel = 6'h00, olog = 6'h00;
	wire        stb, ack, lclk, ldat, lfr;
	wire [7:0]  cmd, addr, wd, rdata;
	wire [3:0]  gates;
	wire [1:0]  pins;
	integer     fail_count = 0, num_checks = 0, i;
	reg  [44:0] vec;
	reg  [10:0] e;
	reg  [7:0]  d, w, t;
	reg         k;
	initial forever #2.5 i_sys_clk = ~i_sys_clk;
	mss_host host (.i_sys_clk(i_sys_clk), .i_ack(ack), .i_rdata(rdata), .o_stb(stb),
		.o_cmd(cmd), .o_addr(addr), .o_wdata(wd), .o_lclk(lclk), .o_ldata(ldat), .o_frame(lfr));
	// Short slot keeps the round robin within a few hundred cycles
	mss_monitor_status_readout_regs #(.TEMP_SLOT_CYC(20)) dut (
		.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_acc_stb(stb), .i_acc_cmd(cmd),
		.i_acc_addr(addr), .i_acc_wdata(wd), .o_acc_rdata(rdata), .o_acc_ack(ack),
		.i_link_clk(lclk), .i_link_data(ldat), .i_link_frame(lfr), .i_safe_state(safe),
		.i_log_full(full), .i_log_busy(busy), .i_temp_enable(ten), .i_temp_raw_ext1(t1),
		.i_temp_raw_ext2(t2), .i_temp_raw_die(t3), .i_out_i2c_sel(osel), .i_out_logic(olog),
		.o_high_voltage_gate_outputs(gates), .o_io_pins(pins));
	// ==========
	// Helpers
	task chk(input [7:0] got, input [7:0] exp);
		begin
			num_checks++;
			if (got !== exp) begin
				fail_count++;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task close_out;
		begin
			if (fail_count == 0 && num_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		begin
			host.acc(8'h52, a, 8'h00, d, k);
			chk(d, exp);
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		begin
			host.acc(8'h51, a, v, d, k);
			chk({7'h00, k}, 8'h01);
		end
	endtask
	task tq(input [7:0] a, input [10:0] x);
		begin
			rd(a, x[10:3]);
			rd(a + 8'h01, {x[2:0], 5'h00});
		end
	endtask
	function [10:0] tc(input [11:0] r);
		tc = ($signed(r) > $signed(12'h3ff)) ? 11'h3ff : r[10:0];
	endfunction
	// ==========
	// Tests
	initial begin
		w = 8'($urandom(32'he5d8));
		repeat (6) @(posedge i_sys_clk);
		#1 i_rst_b = 1'b1;
		rd(8'h70, 8'h00);
		tq(8'h80, 11'h700);
		rd(8'h07, 8'h00);
		{full, busy} = 2'($urandom);
		wr(8'h07, 8'h00);
		rd(8'h08, {1'b0, full, busy, 5'h05});
		safe = 1'b0;
		rd(8'h07, 8'h80);
		safe = 1'b1;
		rd(8'h07, 8'h00);
		vec[44:32] = 13'($urandom);
		vec[31:0] = $urandom;
		host.frame(vec, 45);
		host.frame(~vec, 44);
		for (i = 1; i < 7; i++) begin
			wr(8'h07, 8'(i));
			t = (i == 6) ? {vec[4:0], 3'h5} : vec[52-8*i -: 8];
			rd(8'h08, t);
		end
		rd(8'h07, 8'h86);
		wr(8'h07, 8'hf9);
		rd(8'h08, 8'h00);
		rd(8'h07, 8'h89);
		wr(8'h86, 8'hff);
		rd(8'h86, {5'h00, vec[0], vec[4], vec[2]});
		rd(8'h87, {5'h00, vec[1], vec[5], vec[3]});
		host.acc(8'h33, 8'h70, 8'hff, d, k);
		chk({7'h00, k}, 8'h00);
		for (i = 0; i < 4; i++) begin
			w = 8'($urandom);
			osel = (i < 2) ? {6{i[0]}} : 6'($urandom);
			olog = 6'($urandom);
			wr(8'h70, w);
			rd(8'h70, {2'h0, w[5:0]});
			t = {2'h0, (osel & w[5:0]) | (~osel & olog)};
			chk({4'h0, gates}, {4'h0, t[5:2]});
			chk({6'h00, pins}, {6'h00, t[1:0]});
		end
		t1 = {2'h0, 10'($urandom)};
		t2 = 12'h500;
		t3 = 12'hef0;
		ten = 3'h7;
		repeat (200) @(posedge i_sys_clk);
		tq(8'h80, tc(t1));
		tq(8'h82, tc(t2));
		tq(8'h84, tc(t3));
		e = tc(t1);
		rd(8'h80, e[10:3]);
		t1 = t1 ^ 12'h007;
		repeat (200) @(posedge i_sys_clk);
		rd(8'h81, {e[2:0], 5'h00});
		tq(8'h80, tc(t1));
		ten = 3'h5;
		repeat (5) @(posedge i_sys_clk);
		tq(8'h82, 11'h700);
		close_out;
	end
	// Whole run is about 15 us; this leaves ample margin
	initial begin
		#300000;
		fail_count++;
		close_out;
	end
endmodule
